// File: dtc_timer.sv
/*
 * Two timer/counter channels with shared control and mode registers and
 * capture of two external interrupt request pins.
 * Assumes a same-clock register port (read data one cycle after the read
 * strobe) and vectoring acknowledge pulses from an interrupt controller
 * on the same clock. Pins are asynchronous and are synchronised here.
 */
// Overview of operation
// [RULE1] Channel 1 gated: counts while pin high
// [RULE2] Channel 1 ungated: counts whenever run set
// [RULE3] Channel 0 gated: counts while pin high
// [RULE4] Channel 0 ungated: request pin ignored
// [RULE5] Channel 1 source clear: internal tick
// [RULE6] Channel 1 source set: count pin falls
// [RULE7] Channel 0 source clear: internal tick
// [RULE8] Channel 0 source set: count pin falls
// [RULE9] Mode fields at bits 5:4 and 1:0
// [RULE10] Mode 00: 8-bit counter, 5-bit prescaler
// [RULE11] Mode 01: full 16-bit counter
// [RULE12] Mode 10: low byte reloads from high
// [RULE13] Mode 11: channel 0 low byte timer
// [RULE14] Mode 11: high byte runs on channel 1
// [RULE15] Mode 11 on channel 1 halts it
// [RULE16] Request edge or level sets detect flag
// [RULE17] Vectoring clears flag only in edge mode
// [RULE18] Level mode flag follows inverted pin
// [RULE19] Software picks edge or level trigger
// [RULE20] Control register bit order fixed
// [RULE21] Overflow sets flag; vector or write clears
`timescale 1ns/1ps

module dtc_timer
    import dtc_pkg::*;
#(
    parameter int TICK_DIV = DTC_TICK_DIV
)
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rd_data,
    // External pins
    input  wire logic       counter_pin_zero,
    input  wire logic       counter_pin_one,
    input  wire logic       ext_irq_pin_zero,
    input  wire logic       ext_irq_pin_one,
    // Vectoring acknowledges
    input  wire logic       ovf0_vec,
    input  wire logic       ovf1_vec,
    input  wire logic       ext_irq0_vec,
    input  wire logic       ext_irq1_vec,
    // Flag outputs
    output logic            ovf0_flag,
    output logic            ovf1_flag,
    output logic            ext_irq0_flag,
    output logic            ext_irq1_flag
);

    // Count step: returns {overflow, high byte, low byte}
    function automatic logic [16:0] dtc_step(
        input dtc_mode_t  m,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic       inc
    );
        logic [16:0] r;
        r = {1'b0, hi, lo};
        if (inc)
        begin
            case (m)
                DTC_MODE_PRESCALE:
                begin
                    if (lo[4:0] == DTC_PRE_MAX)
                    begin
                        r = {hi == DTC_BYTE_MAX, hi + 8'h01,
                             lo[7:5], 5'h00};
                    end
                    else
                    begin
                        r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
                    end
                end
                DTC_MODE_WIDE:
                    r = {1'b0, hi, lo} + 17'h00001;
                DTC_MODE_RELOAD:
                begin
                    if (lo == DTC_BYTE_MAX)
                        r = {1'b1, hi, hi};
                    else
                        r = {1'b0, hi, lo + 8'h01};
                end
                default:
                    r = {lo == DTC_BYTE_MAX, hi, lo + 8'h01};
            endcase
        end
        return r;
    endfunction

    // Register state
    logic [7:0]     mode_reg;
    logic [7:0]     lo0_reg;
    logic [7:0]     hi0_reg;
    logic [7:0]     lo1_reg;
    logic [7:0]     hi1_reg;
    logic           run0_reg;
    logic           run1_reg;
    logic           ovf0_reg;
    logic           ovf1_reg;
    logic           irq0_type_reg;
    logic           irq1_type_reg;
    logic           irq0_flag_reg;
    logic           irq1_flag_reg;
    logic [7:0]     rd_data_reg;

    // Pin synchronisers: 0 cnt0, 1 cnt1, 2 irq0, 3 irq1
    logic [3:0]     pin_meta;
    logic [3:0]     pin_sync;
    logic [3:0]     pin_prev;
    logic [3:0]     pin_fall;

    // Internal tick divider
    logic [DTC_TICK_W-1:0] tick_cnt;
    logic                  tick;

    // Decoded controls
    dtc_mode_t      mode0;
    dtc_mode_t      mode1;
    logic           gate0;
    logic           gate1;
    logic           src0;
    logic           src1;
    logic           en0;
    logic           en1;
    logic           inc0;
    logic           inc1;
    logic           inc_hi0;
    logic [16:0]    step0;
    logic [16:0]    step1;
    logic           ovf0_set;
    logic           ovf1_set;
    logic           wr_ctl;

    // Two-stage synchronisers, then a delayed copy for edges
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_meta <= 4'hF;
            pin_sync <= 4'hF;
            pin_prev <= 4'hF;
        end
        else
        begin
            pin_meta <= {ext_irq_pin_one, ext_irq_pin_zero,
                         counter_pin_one, counter_pin_zero};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_fall = pin_prev & ~pin_sync;

    // Internal clock divider producing a one-cycle tick
    always_ff @(posedge mclk)
    begin
        if (rst)
            tick_cnt <= '0;
        else if (tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + DTC_TICK_W'(1);
    end

    assign tick = (tick_cnt == DTC_TICK_W'(TICK_DIV - 1));

    // Mode register fields
    assign mode0 = dtc_mode_t'(mode_reg[DTC_MODE_SEL0 +: 2]); // see [RULE9]
    assign mode1 = dtc_mode_t'(mode_reg[DTC_MODE_SEL1 +: 2]); // see [RULE9]
    assign gate0 = mode_reg[DTC_MODE_GATE0];
    assign gate1 = mode_reg[DTC_MODE_GATE1];
    assign src0  = mode_reg[DTC_MODE_SRC0];
    assign src1  = mode_reg[DTC_MODE_SRC1];

    // Run gating by the request pin level
    assign en0 = run0_reg & (~gate0 | pin_sync[2]); // see [RULE3] [RULE4]
    assign en1 = run1_reg & (~gate1 | pin_sync[3]); // see [RULE1] [RULE2]

    // Count source: tick or falling edge on the count pin
    assign inc0 = en0 & (src0 ? pin_fall[0] : tick); // see [RULE7] [RULE8]
    assign inc1 = en1 & (src1 ? pin_fall[1] : tick)
                & (mode1 != DTC_MODE_SPLIT);          // see [RULE5] [RULE6]

    // Split mode: channel 0 high byte is a timer run by channel 1's bit
    assign inc_hi0 = (mode0 == DTC_MODE_SPLIT) & run1_reg & tick;

    // Next counts per channel
    assign step0 = dtc_step(mode0, lo0_reg, hi0_reg, inc0); // see [RULE13]
    assign step1 = dtc_step(mode1, lo1_reg, hi1_reg, inc1); // see [RULE15]

    // Overflow events; split mode lends channel 1's flag to high byte 0
    assign ovf0_set = step0[16];
    assign ovf1_set = (mode0 == DTC_MODE_SPLIT)
                    ? (inc_hi0 & (hi0_reg == DTC_BYTE_MAX)) // see [RULE14]
                    : step1[16];

    assign wr_ctl = wr_stb & (addr == DTC_ADDR_CTL);

    // Mode register
    always_ff @(posedge mclk)
    begin
        if (rst)
            mode_reg <= DTC_RST_BYTE;
        else if (wr_stb && addr == DTC_ADDR_MODE)
            mode_reg <= wr_data;
    end

    // Channel 0 low byte; a software write wins over counting
    always_ff @(posedge mclk)
    begin
        if (rst)
            lo0_reg <= DTC_RST_BYTE;
        else if (wr_stb && addr == DTC_ADDR_LO0)
            lo0_reg <= wr_data;
        else
            lo0_reg <= step0[7:0]; // see [RULE10] [RULE11] [RULE12]
    end

    // Channel 0 high byte
    always_ff @(posedge mclk)
    begin
        if (rst)
            hi0_reg <= DTC_RST_BYTE;
        else if (wr_stb && addr == DTC_ADDR_HI0)
            hi0_reg <= wr_data;
        else if (mode0 == DTC_MODE_SPLIT)
            hi0_reg <= hi0_reg + {7'h00, inc_hi0}; // see [RULE14]
        else
            hi0_reg <= step0[15:8]; // see [RULE10] [RULE11]
    end

    // Channel 1 low byte
    always_ff @(posedge mclk)
    begin
        if (rst)
            lo1_reg <= DTC_RST_BYTE;
        else if (wr_stb && addr == DTC_ADDR_LO1)
            lo1_reg <= wr_data;
        else
            lo1_reg <= step1[7:0];
    end

    // Channel 1 high byte
    always_ff @(posedge mclk)
    begin
        if (rst)
            hi1_reg <= DTC_RST_BYTE;
        else if (wr_stb && addr == DTC_ADDR_HI1)
            hi1_reg <= wr_data;
        else
            hi1_reg <= step1[15:8];
    end

    // Run and trigger type bits, software only
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            run0_reg      <= DTC_RST_BIT;
            run1_reg      <= DTC_RST_BIT;
            irq0_type_reg <= DTC_RST_BIT;
            irq1_type_reg <= DTC_RST_BIT;
        end
        else if (wr_ctl)
        begin
            run0_reg      <= wr_data[DTC_CTL_RUN0];
            run1_reg      <= wr_data[DTC_CTL_RUN1];
            irq0_type_reg <= wr_data[DTC_CTL_IRQ0T]; // see [RULE19]
            irq1_type_reg <= wr_data[DTC_CTL_IRQ1T]; // see [RULE19]
        end
    end

    // Overflow flags: set wins over vectoring and software writes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ovf0_reg <= DTC_RST_BIT;
            ovf1_reg <= DTC_RST_BIT;
        end
        else
        begin
            if (ovf0_set)
                ovf0_reg <= 1'b1; // see [RULE21]
            else if (ovf0_vec)
                ovf0_reg <= 1'b0;
            else if (wr_ctl)
                ovf0_reg <= wr_data[DTC_CTL_OVF0];
            if (ovf1_set)
                ovf1_reg <= 1'b1; // see [RULE21]
            else if (ovf1_vec)
                ovf1_reg <= 1'b0;
            else if (wr_ctl)
                ovf1_reg <= wr_data[DTC_CTL_OVF1];
        end
    end

    // Request detect flags: edge mode latches, level mode follows inverted pin
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq0_flag_reg <= DTC_RST_BIT;
            irq1_flag_reg <= DTC_RST_BIT;
        end
        else
        begin
            if (!irq0_type_reg)
                irq0_flag_reg <= ~pin_sync[2]; // see [RULE18]
            else if (pin_fall[2])
                irq0_flag_reg <= 1'b1;         // see [RULE16]
            else if (ext_irq0_vec)
                irq0_flag_reg <= 1'b0;         // see [RULE17]
            else if (wr_ctl)
                irq0_flag_reg <= wr_data[DTC_CTL_IRQ0F];
            if (!irq1_type_reg)
                irq1_flag_reg <= ~pin_sync[3]; // see [RULE18]
            else if (pin_fall[3])
                irq1_flag_reg <= 1'b1;         // see [RULE16]
            else if (ext_irq1_vec)
                irq1_flag_reg <= 1'b0;         // see [RULE17]
            else if (wr_ctl)
                irq1_flag_reg <= wr_data[DTC_CTL_IRQ1F];
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge mclk)
    begin
        if (rst || !rd_stb)
            rd_data_reg <= DTC_RST_BYTE;
        else
        begin
            case (addr)
                DTC_ADDR_CTL:
                    rd_data_reg <= {ovf1_reg, run1_reg, ovf0_reg, run0_reg,
                                    irq1_flag_reg, irq1_type_reg,
                                    irq0_flag_reg, irq0_type_reg
                                   }; // see [RULE20]
                DTC_ADDR_MODE: rd_data_reg <= mode_reg;
                DTC_ADDR_LO0:  rd_data_reg <= lo0_reg;
                DTC_ADDR_HI0:  rd_data_reg <= hi0_reg;
                DTC_ADDR_LO1:  rd_data_reg <= lo1_reg;
                DTC_ADDR_HI1:  rd_data_reg <= hi1_reg;
                default:       rd_data_reg <= DTC_RST_BYTE;
            endcase
        end
    end

    // Outputs straight from flops
    assign rd_data       = rd_data_reg;
    assign ovf0_flag     = ovf0_reg;
    assign ovf1_flag     = ovf1_reg;
    assign ext_irq0_flag = irq0_flag_reg;
    assign ext_irq1_flag = irq1_flag_reg;

    // Checks on the counting and flag logic
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    gate_one_a: assert property ( // see [RULE1]
        (gate1 && !pin_sync[3]) |-> !inc1)
        else $error("channel 1 counted with gate pin low");

    free_one_a: assert property ( // see [RULE2] [RULE5]
        (run1_reg && !gate1 && !src1 && mode1 != DTC_MODE_SPLIT)
        |-> (inc1 == tick))
        else $error("channel 1 ungated tick count wrong");

    gate_zero_a: assert property ( // see [RULE3]
        (gate0 && !pin_sync[2]) |-> !inc0)
        else $error("channel 0 counted with gate pin low");

    free_zero_a: assert property ( // see [RULE4] [RULE7]
        (run0_reg && !gate0 && !src0) |-> (inc0 == tick))
        else $error("channel 0 ungated tick count wrong");

    pin_count_a: assert property ( // see [RULE8]
        (en0 && src0) |-> (inc0 == (pin_prev[0] && !pin_sync[0])))
        else $error("channel 0 pin count not on falling edge");

    prescale_hold_a: assert property ( // see [RULE10]
        (mode0 == DTC_MODE_PRESCALE && lo0_reg[4:0] != DTC_PRE_MAX
         && !wr_stb) |=> (hi0_reg == $past(hi0_reg)))
        else $error("high byte moved before prescaler wrapped");

    wide_carry_a: assert property ( // see [RULE11] [RULE21]
        (inc0 && mode0 == DTC_MODE_WIDE && lo0_reg == DTC_BYTE_MAX
         && hi0_reg == DTC_BYTE_MAX && !wr_stb)
        |=> (ovf0_reg && lo0_reg == 8'h00 && hi0_reg == 8'h00))
        else $error("16-bit rollover did not set overflow");

    reload_low_a: assert property ( // see [RULE12]
        (inc0 && mode0 == DTC_MODE_RELOAD && lo0_reg == DTC_BYTE_MAX
         && !wr_stb) |=> (lo0_reg == $past(hi0_reg)))
        else $error("low byte did not reload from high byte");

    split_high_a: assert property ( // see [RULE14]
        (mode0 == DTC_MODE_SPLIT && run1_reg && tick && !wr_stb)
        |=> (hi0_reg == $past(hi0_reg) + 8'h01))
        else $error("split high byte did not advance");

    halt_one_a: assert property ( // see [RULE15]
        (mode1 == DTC_MODE_SPLIT && !wr_stb) |=>
        (lo1_reg == $past(lo1_reg) && hi1_reg == $past(hi1_reg)))
        else $error("channel 1 moved while halted");

    edge_set_a: assert property ( // see [RULE16]
        (irq0_type_reg && pin_fall[2]) |=> irq0_flag_reg)
        else $error("falling edge did not set detect flag");

    edge_clear_a: assert property ( // see [RULE17]
        (irq0_type_reg && ext_irq0_vec && !pin_fall[2] && !wr_ctl)
        |=> !irq0_flag_reg)
        else $error("vectoring did not clear edge flag");

    level_track_a: assert property ( // see [RULE18]
        !irq1_type_reg |=> (irq1_flag_reg == !$past(pin_sync[3])))
        else $error("level flag does not follow inverted pin");

endmodule

// File: dtc_pkg.sv
/*
 * Shared constants for the dual timer/counter block: register offsets,
 * bit positions, reset values, mode codes and the internal tick rate.
 * Assumes an 8-bit register port with byte-wide offsets.
 */
package dtc_pkg;

    // Register offsets
    localparam logic [7:0] DTC_ADDR_CTL  = 8'h88;
    localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
    localparam logic [7:0] DTC_ADDR_LO0  = 8'h8A;
    localparam logic [7:0] DTC_ADDR_LO1  = 8'h8B;
    localparam logic [7:0] DTC_ADDR_HI0  = 8'h8C;
    localparam logic [7:0] DTC_ADDR_HI1  = 8'h8D;

    // Control register bit positions
    localparam int DTC_CTL_OVF1  = 7;
    localparam int DTC_CTL_RUN1  = 6;
    localparam int DTC_CTL_OVF0  = 5;
    localparam int DTC_CTL_RUN0  = 4;
    localparam int DTC_CTL_IRQ1F = 3;
    localparam int DTC_CTL_IRQ1T = 2;
    localparam int DTC_CTL_IRQ0F = 1;
    localparam int DTC_CTL_IRQ0T = 0;

    // Mode register bit positions
    localparam int DTC_MODE_GATE1 = 7;
    localparam int DTC_MODE_SRC1  = 6;
    localparam int DTC_MODE_SEL1  = 4;
    localparam int DTC_MODE_GATE0 = 3;
    localparam int DTC_MODE_SRC0  = 2;
    localparam int DTC_MODE_SEL0  = 0;

    // Reset values
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;
    localparam logic       DTC_RST_BIT  = 1'b0;

    // Prescaler field limit of the low byte in the prescaled mode, and the full byte limit
    localparam logic [4:0] DTC_PRE_MAX = 5'h1F;
    localparam logic [7:0] DTC_BYTE_MAX = 8'hFF;

    // Internal clock divider: system clocks per count tick
    localparam int DTC_TICK_DIV = 12;
    localparam int DTC_TICK_W   = 4;

    // Operating modes, in field-code order 00..11
    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE,
        DTC_MODE_WIDE,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_t;

endpackage

// File: dtc_pins_model.sv
/*
 * Far-side model of the pins around the dual timer block: two count
 * pins and two request pins, resting high as with external pull-ups.
 * Assumes the bench calls its tasks from one process on mclk.
 */
`timescale 1ns/1ps

module dtc_pins_model
(
    // Clock
    input  wire logic mclk,
    // Pins towards the block
    output logic      counter_pin_zero,
    output logic      counter_pin_one,
    output logic      ext_irq_pin_zero,
    output logic      ext_irq_pin_one
);
    // Pins rest high until a task moves them
    initial
    begin
        counter_pin_zero = 1'b1;
        counter_pin_one  = 1'b1;
        ext_irq_pin_zero = 1'b1;
        ext_irq_pin_one  = 1'b1;
    end

    // Moves one pin just after the next rising edge
    task automatic drive(input int pin, input logic v);
        @(posedge mclk);
        case (pin)
            0: counter_pin_zero <= v;
            1: counter_pin_one  <= v;
            2: ext_irq_pin_zero <= v;
            default: ext_irq_pin_one <= v;
        endcase
    endtask

    // Falling edges on one pin, each phase held ph cycles (1 is quickest)
    task automatic count_pulses(input int pin, input int n, input int ph);
        for (int i = 0; i < n; i++)
        begin
            drive(pin, 1'b0);
            repeat (ph - 1) @(posedge mclk);
            drive(pin, 1'b1);
            repeat (ph - 1) @(posedge mclk);
        end
    endtask
endmodule

// File: dtc_timer_tb_top.sv
/*
 * Self-checking bench for the dual timer block: register access, modes,
 * gating, count sources, overflow and request flag handling.
 * Assumes the pin model beside it and a shortened internal tick.
 */
`timescale 1ns/1ps

module dtc_timer_tb_top;
    import dtc_pkg::*;

    logic       mclk;
    logic       rst;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rd_data;
    logic       cp0, cp1, rq0, rq1;
    logic [3:0] vec;
    logic       ovf0_flag, ovf1_flag, ext_irq0_flag, ext_irq1_flag;
    int         bad_count;
    int         cmp_count;
    int         cyc;

    // Block under test, tick shortened to two clocks
    dtc_timer #(.TICK_DIV(2)) u_dtc_timer (
        .mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .counter_pin_zero(cp0), .counter_pin_one(cp1),
        .ext_irq_pin_zero(rq0), .ext_irq_pin_one(rq1),
        .ovf0_vec(vec[0]), .ovf1_vec(vec[1]),
        .ext_irq0_vec(vec[2]), .ext_irq1_vec(vec[3]),
        .ovf0_flag(ovf0_flag), .ovf1_flag(ovf1_flag),
        .ext_irq0_flag(ext_irq0_flag), .ext_irq1_flag(ext_irq1_flag)
    );

    // Pins on the far side
    dtc_pins_model u_dtc_pins_model (
        .mclk(mclk), .counter_pin_zero(cp0), .counter_pin_one(cp1),
        .ext_irq_pin_zero(rq0), .ext_irq_pin_one(rq1)
    );

    // Verdict and end of run
    task automatic report_and_stop;
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Byte and flag comparisons
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge mclk);
        wr_stb  <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        cmp_byte(rd_data, exp);
    endtask

    // One-cycle vectoring acknowledge: 0 ovf0, 1 ovf1, 2 irq0, 3 irq1
    task automatic pulse_vec(input int k);
        @(posedge mclk);
        vec[k] <= 1'b1;
        @(posedge mclk);
        vec[k] <= 1'b0;
    endtask

    // Lets the pin synchronisers and flags settle
    task automatic settle;
        repeat (6) @(posedge mclk);
    endtask

    // Waits for channel 0 overflow under a bound
    task automatic wait_ovf0(input int lim);
        int n;
        n = 0;
        while (ovf0_flag !== 1'b1 && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
    endtask

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard
    initial
    begin
        cyc = 0;
        forever
        begin
            @(posedge mclk);
            cyc++;
            if (cyc == 5000)
            begin
                bad_count++;
                report_and_stop();
            end
        end
    end

    // Main sequence
    initial
    begin
        logic [7:0] regs [6];
        regs = '{DTC_ADDR_CTL, DTC_ADDR_MODE, DTC_ADDR_LO0,
                 DTC_ADDR_LO1, DTC_ADDR_HI0, DTC_ADDR_HI1};
        bad_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        vec = 4'h0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        // Reset values, unmapped place, read/write of count and mode bytes
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        wr(8'h8E, 8'hFF);
        rd_chk(8'h8E, 8'h00);
        for (int i = 1; i < 6; i++) wr(regs[i], 8'hA0 | 8'(i));
        for (int i = 1; i < 6; i++)
            rd_chk(regs[i], 8'hA0 | 8'(i));
        // Internal tick, 16-bit mode rolls into overflow
        wr(DTC_ADDR_LO0, 8'hFE);
        wr(DTC_ADDR_HI0, 8'hFF);
        wr(DTC_ADDR_MODE, 8'h01);
        wr(DTC_ADDR_CTL, 8'h10);
        wait_ovf0(200);
        cmp_bit(ovf0_flag, 1'b1);
        wr(DTC_ADDR_CTL, 8'h20);
        rd_chk(DTC_ADDR_CTL, 8'h20);
        rd_chk(DTC_ADDR_HI0, 8'h00);
        pulse_vec(0);
        settle();
        cmp_bit(ovf0_flag, 1'b0);
        // Pin sources, ungated, request pins held low in level mode
        u_dtc_pins_model.drive(2, 1'b0);
        u_dtc_pins_model.drive(3, 1'b0);
        wr(DTC_ADDR_LO0, 8'h00);
        wr(DTC_ADDR_LO1, 8'h00);
        wr(DTC_ADDR_MODE, 8'h55);
        wr(DTC_ADDR_CTL, 8'h50);
        u_dtc_pins_model.count_pulses(0, 5, 2);
        u_dtc_pins_model.count_pulses(1, 3, 5);
        settle();
        rd_chk(DTC_ADDR_LO0, 8'h05);
        rd_chk(DTC_ADDR_LO1, 8'h03);
        cmp_bit(ext_irq0_flag, 1'b1);
        cmp_bit(ext_irq1_flag, 1'b1);
        pulse_vec(2);
        settle();
        cmp_bit(ext_irq0_flag, 1'b1);
        // Gated: pins low block counting, pins high let it through
        wr(DTC_ADDR_MODE, 8'hDD);
        wr(DTC_ADDR_LO0, 8'h00);
        wr(DTC_ADDR_LO1, 8'h00);
        u_dtc_pins_model.count_pulses(0, 3, 2);
        u_dtc_pins_model.count_pulses(1, 3, 2);
        settle();
        rd_chk(DTC_ADDR_LO0, 8'h00);
        rd_chk(DTC_ADDR_LO1, 8'h00);
        u_dtc_pins_model.drive(2, 1'b1);
        u_dtc_pins_model.drive(3, 1'b1);
        settle();
        cmp_bit(ext_irq0_flag, 1'b0);
        u_dtc_pins_model.count_pulses(0, 2, 2);
        u_dtc_pins_model.count_pulses(1, 2, 2);
        settle();
        rd_chk(DTC_ADDR_LO0, 8'h02);
        rd_chk(DTC_ADDR_LO1, 8'h02);
        // Prescaled mode: carry out of the 5-bit field, upper bits kept
        wr(DTC_ADDR_CTL, 8'h10);
        wr(DTC_ADDR_MODE, 8'h04);
        wr(DTC_ADDR_LO0, 8'hFE);
        wr(DTC_ADDR_HI0, 8'h00);
        u_dtc_pins_model.count_pulses(0, 3, 2);
        settle();
        rd_chk(DTC_ADDR_LO0, 8'hE1);
        rd_chk(DTC_ADDR_HI0, 8'h01);
        // Reload mode: low byte reloads from high byte on overflow
        wr(DTC_ADDR_MODE, 8'h06);
        wr(DTC_ADDR_HI0, 8'h80);
        wr(DTC_ADDR_LO0, 8'hFE);
        u_dtc_pins_model.count_pulses(0, 3, 2);
        settle();
        rd_chk(DTC_ADDR_LO0, 8'h81);
        rd_chk(DTC_ADDR_HI0, 8'h80);
        cmp_bit(ovf0_flag, 1'b1);
        wr(DTC_ADDR_CTL, 8'h10);
        settle();
        cmp_bit(ovf0_flag, 1'b0);
        // Split mode: low byte on pin, high byte on run1, channel 1 halted
        wr(DTC_ADDR_CTL, 8'h00);
        wr(DTC_ADDR_MODE, 8'h77);
        wr(DTC_ADDR_LO0, 8'h00);
        wr(DTC_ADDR_LO1, 8'h00);
        wr(DTC_ADDR_HI0, 8'hFF);
        pulse_vec(1);
        wr(DTC_ADDR_CTL, 8'h50);
        u_dtc_pins_model.count_pulses(0, 4, 2);
        u_dtc_pins_model.count_pulses(1, 4, 2);
        settle();
        rd_chk(DTC_ADDR_LO0, 8'h04);
        rd_chk(DTC_ADDR_LO1, 8'h00);
        cmp_bit(ovf1_flag, 1'b1);
        cmp_bit(ovf0_flag, 1'b0);
        pulse_vec(1);
        settle();
        cmp_bit(ovf1_flag, 1'b0);
        // Channel 1 on its pin: reload mode, then prescaled mode
        wr(DTC_ADDR_CTL, 8'h00);
        wr(DTC_ADDR_MODE, 8'h60);
        wr(DTC_ADDR_HI1, 8'hF0);
        wr(DTC_ADDR_LO1, 8'hFE);
        wr(DTC_ADDR_CTL, 8'h40);
        u_dtc_pins_model.count_pulses(1, 3, 2);
        settle();
        rd_chk(DTC_ADDR_LO1, 8'hF1);
        cmp_bit(ovf1_flag, 1'b1);
        wr(DTC_ADDR_MODE, 8'h40);
        wr(DTC_ADDR_LO1, 8'h3F);
        wr(DTC_ADDR_HI1, 8'h07);
        u_dtc_pins_model.count_pulses(1, 1, 2);
        settle();
        rd_chk(DTC_ADDR_HI1, 8'h08);
        rd_chk(DTC_ADDR_LO1, 8'h20);
        // Edge mode requests latch until vectored
        wr(DTC_ADDR_CTL, 8'h05);
        u_dtc_pins_model.drive(2, 1'b0);
        u_dtc_pins_model.drive(3, 1'b0);
        settle();
        u_dtc_pins_model.drive(2, 1'b1);
        u_dtc_pins_model.drive(3, 1'b1);
        settle();
        cmp_bit(ext_irq0_flag, 1'b1);
        cmp_bit(ext_irq1_flag, 1'b1);
        rd_chk(DTC_ADDR_CTL, 8'h0F);
        pulse_vec(2);
        pulse_vec(3);
        settle();
        cmp_bit(ext_irq0_flag, 1'b0);
        cmp_bit(ext_irq1_flag, 1'b0);
        report_and_stop();
    end
endmodule
